// *** hdl/srtmr_timer.sv ***
// Split reload timer: 16-bit or dual 8-bit auto-reload counter
`default_nettype none
// Notes on behaviour
// - Count held in low and high byte registers
// - Sources: system clock, /12, external /8
// - Split select zero gives 16-bit reload timer
// - 16-bit wrap loads reload pair, sets high flag
// - 16-bit overflow requests interrupt when enabled
// - Low byte wrap also interrupts if enabled
// - Split one with qualifier clear gives two independent 8-bit timers
// - Each byte reloads from its own reload byte
// - Run control gates only high byte in split
// - Per-byte clock select picks source in split; 16-bit uses low-byte select
// - Split: each byte wrap sets its flag
// - Split interrupts: high always, low if enabled
// - Flags cleared only by software writes
// - Control bit layout, all reset zero
// - Low flag set on low wrap any mode
// - Unused control bits read zero, ignore writes
module srtmr_timer (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire srtmr_pkg::srtmr_sfr_t SFR_REQ,
    output logic [7:0] SFR_RDATA,
    input wire logic TIMER_IRQ_ENABLE,
    input wire logic HIGH_BYTE_CLOCK_SELECT,
    input wire logic LOW_BYTE_CLOCK_SELECT,
    input wire logic SPLIT_QUALIFIER_BIT,
    input wire logic EXT_CLK,
    output logic IRQ
);
    import srtmr_pkg::*;

    logic [7:0] control_r;
    logic [7:0] control_nxt;
    logic [7:0] reload_low_r;
    logic [7:0] reload_high_r;
    logic [7:0] count_low_r;
    logic [7:0] count_low_nxt;
    logic [7:0] count_high_r;
    logic [7:0] count_high_nxt;
    logic [3:0] div12_r;
    logic [2:0] div8_r;
    logic ext_sync1_r;
    logic ext_sync2_r;
    logic ext_prev_r;
    logic [7:0] rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Clock enables
    wire tick_div12 = (div12_r == SYS_DIV_LAST);
    wire ext_rise = ext_sync2_r & ~ext_prev_r;
    wire tick_ext8 = ext_rise & (div8_r == EXT_DIV_LAST);

    function automatic logic src_tick(input logic sel_sys, input logic ext_sel,
                                      input logic t12, input logic t8);
        srtmr_src_t src;
        src = sel_sys ? SRC_SYS : (ext_sel ? SRC_EXT8 : SRC_DIV12);
        unique case (src)
            SRC_SYS: src_tick = 1'b1;
            SRC_EXT8: src_tick = t8;
            SRC_DIV12: src_tick = t12;
            default: src_tick = 1'b0;
        endcase
    endfunction

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            div12_r <= '0;
        end else begin
            div12_r <= tick_div12 ? 4'h0 : div12_r + 4'h1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ext_sync1_r <= 1'b0;
            ext_sync2_r <= 1'b0;
            ext_prev_r <= 1'b0;
            div8_r <= '0;
        end else begin
            ext_sync1_r <= EXT_CLK;
            ext_sync2_r <= ext_sync1_r;
            ext_prev_r <= ext_sync2_r;
            if (ext_rise) begin
                div8_r <= div8_r + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode and per-byte enables
    wire split_mode = control_r[BIT_SPLIT] & ~SPLIT_QUALIFIER_BIT;
    wire run = control_r[BIT_RUN];
    wire ext_sel = control_r[BIT_EXT_SEL];
    // 16-bit mode uses the low-byte select for the whole counter
    wire tick_low = src_tick(LOW_BYTE_CLOCK_SELECT, ext_sel, tick_div12, tick_ext8);
    wire tick_high = src_tick(HIGH_BYTE_CLOCK_SELECT, ext_sel, tick_div12, tick_ext8);
    wire low_inc = split_mode ? tick_low : (run & tick_low);
    wire high_inc = split_mode ? (run & tick_high) : (run & tick_low & count_low_r == 8'hff);
    wire low_wrap = low_inc & (count_low_r == 8'hff);
    wire high_wrap = high_inc & (count_high_r == 8'hff);
    wire full_wrap = ~split_mode & low_wrap & high_wrap;

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    wire wr_ctrl = SFR_REQ.wr & (SFR_REQ.addr == ADDR_CONTROL);
    wire wr_rl_low = SFR_REQ.wr & (SFR_REQ.addr == ADDR_RELOAD_LOW);
    wire wr_rl_high = SFR_REQ.wr & (SFR_REQ.addr == ADDR_RELOAD_HIGH);
    wire wr_cnt_low = SFR_REQ.wr & (SFR_REQ.addr == ADDR_COUNT_LOW);
    wire wr_cnt_high = SFR_REQ.wr & (SFR_REQ.addr == ADDR_COUNT_HIGH);

    wire [7:0] ctrl_base = wr_ctrl ? (SFR_REQ.wdata & CONTROL_WMASK) : control_r;
    wire set_high_flag = split_mode ? high_wrap : full_wrap;
    wire [7:0] flag_set = {set_high_flag, low_wrap, 6'h00};
    // Hardware set wins over a software clear in the same cycle
    assign control_nxt = ctrl_base | flag_set;

    wire [7:0] low_step = count_low_r + 8'h01;
    wire [7:0] high_step = count_high_r + 8'h01;
    // 16-bit reload only on full wrap; split reloads each byte alone
    wire low_reload = split_mode ? low_wrap : full_wrap;
    wire high_reload = split_mode ? high_wrap : full_wrap;

    assign count_low_nxt = wr_cnt_low ? SFR_REQ.wdata :
                           low_reload ? reload_low_r :
                           low_inc ? low_step : count_low_r;
    assign count_high_nxt = wr_cnt_high ? SFR_REQ.wdata :
                            high_reload ? reload_high_r :
                            high_inc ? high_step : count_high_r;

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            control_r <= CONTROL_RESET;
            reload_low_r <= BYTE_RESET;
            reload_high_r <= BYTE_RESET;
            count_low_r <= BYTE_RESET;
            count_high_r <= BYTE_RESET;
        end else begin
            control_r <= control_nxt;
            if (wr_rl_low) begin
                reload_low_r <= SFR_REQ.wdata;
            end
            if (wr_rl_high) begin
                reload_high_r <= SFR_REQ.wdata;
            end
            count_low_r <= count_low_nxt;
            count_high_r <= count_high_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and interrupt request
    wire [7:0] rd_mux = (SFR_REQ.addr == ADDR_CONTROL) ? control_r :
                        (SFR_REQ.addr == ADDR_RELOAD_LOW) ? reload_low_r :
                        (SFR_REQ.addr == ADDR_RELOAD_HIGH) ? reload_high_r :
                        (SFR_REQ.addr == ADDR_COUNT_LOW) ? count_low_r :
                        (SFR_REQ.addr == ADDR_COUNT_HIGH) ? count_high_r : 8'h00;

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rdata_r <= 8'h00;
        end else if (SFR_REQ.rd) begin
            rdata_r <= rd_mux;
        end
    end
    assign SFR_RDATA = rdata_r;

    // Level request while the high flag or the enabled low flag stands; software sorts out the source
    wire irq_high = control_r[BIT_HIGH_FLAG];
    wire irq_low = control_r[BIT_LOW_FLAG] & control_r[BIT_LOW_IRQ_EN];
    assign IRQ = TIMER_IRQ_ENABLE & (irq_high | irq_low);
endmodule // srtmr_timer
`default_nettype wire

// *** hdl/srtmr_pkg.sv ***
// Package of constants and types for the split reload timer
`default_nettype none
package srtmr_pkg;
    // Special-function register addresses (byte addresses on the SFR bus)
    localparam logic [7:0] ADDR_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
    // Control register field positions
    localparam int BIT_HIGH_FLAG = 7;
    localparam int BIT_LOW_FLAG = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_EXT_SEL = 0;
    // Writable bits of the control register; bits 4 and 1 read zero
    localparam logic [7:0] CONTROL_WMASK = 8'hed;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Clock dividers
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;
    localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
    localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } srtmr_sfr_t;

    typedef enum logic [1:0] {
        SRC_DIV12 = 2'b00,
        SRC_EXT8 = 2'b01,
        SRC_SYS = 2'b10
    } srtmr_src_t;
endpackage
`default_nettype wire

// *** test/srtmr_props.sv ***
// Checker for the split reload timer ports
`default_nettype none
module srtmr_props (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire srtmr_pkg::srtmr_sfr_t SFR_REQ,
    input wire logic [7:0] SFR_RDATA,
    input wire logic TIMER_IRQ_ENABLE,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    import srtmr_pkg::*;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    wire rc = SFR_REQ.rd && !SFR_REQ.wr && SFR_REQ.addr == ADDR_CONTROL;
    wire wc = SFR_REQ.wr && SFR_REQ.addr == ADDR_CONTROL;
    wire rh = SFR_REQ.rd && !SFR_REQ.wr && SFR_REQ.addr == ADDR_RELOAD_HIGH;
    wire wh = SFR_REQ.wr && SFR_REQ.addr == ADDR_RELOAD_HIGH;
    ////////////////////////////////////////////////////////////////
    a_irq_gated: assert property (!TIMER_IRQ_ENABLE |-> !IRQ)
        else $error("irq without enable");
    a_unused_zero: assert property (rc |=> SFR_RDATA[4] == 1'b0 && SFR_RDATA[1] == 1'b0)
        else $error("unused bit set");
    a_irq_holds: assert property (IRQ && !SFR_REQ.wr ##1 TIMER_IRQ_ENABLE |-> IRQ)
        else $error("irq dropped");
    a_reload_back: assert property (wh ##1 rh |=> SFR_RDATA == $past(SFR_REQ.wdata, 2))
        else $error("reload readback");
    a_ctrl_back: assert property (wc ##1 rc |=>
        (SFR_RDATA & 8'h2d) == ($past(SFR_REQ.wdata, 2) & 8'h2d))
        else $error("control readback");
    a_high_irq: assert property (rc ##1 SFR_RDATA[7] && TIMER_IRQ_ENABLE |-> IRQ)
        else $error("high flag no irq");
    a_low_irq: assert property (rc ##1 &SFR_RDATA[6:5] && TIMER_IRQ_ENABLE |-> IRQ)
        else $error("low flag no irq");
    a_reset_read: assert property (disable iff (1'b0) SYS_RST |=> SFR_RDATA == 8'h00)
        else $error("read data not reset");
    cover property ($rose(IRQ));
    cover property (rc ##1 SFR_RDATA[6]);
    cover property (wc && SFR_REQ.wdata[3]);
endmodule // srtmr_props
bind srtmr_timer srtmr_props chk_u (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA), .TIMER_IRQ_ENABLE(TIMER_IRQ_ENABLE), .IRQ(IRQ));
`default_nettype wire

// *** test/srtmr_timer_bench.sv ***
// Self-checking bench for the split reload timer
`default_nettype none
module srtmr_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import srtmr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    srtmr_sfr_t req = '0;
    logic [7:0] rdata;
    logic ien = 1'b0;
    logic hsel = 1'b0;
    logic lsel = 1'b0;
    logic ext = 1'b0;
    logic qual = 1'b0;
    wire irq;
    int err_count = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    always #130 ext = ~ext;
    srtmr_timer dut_u (.CORE_CLK(clk), .SYS_RST(rst), .SFR_REQ(req), .SFR_RDATA(rdata),
        .TIMER_IRQ_ENABLE(ien), .HIGH_BYTE_CLOCK_SELECT(hsel), .LOW_BYTE_CLOCK_SELECT(lsel),
        .SPLIT_QUALIFIER_BIT(qual), .EXT_CLK(ext), .IRQ(irq));
    ////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
        samples_checked++;
        if (((g >= lo) && (g <= hi)) !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t got %h want %h..%h", $time, g, lo, hi);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd = 1'b0;
        chk(rdata, lo, hi);
    endtask
    task ci(input logic e);
        @(negedge clk);
        chk({7'h0, irq}, {7'h0, e}, {7'h0, e});
    endtask
    task close_out;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) rd(8'hc8 + 8'(i), 8'h00, 8'h00);
        wr(ADDR_CONTROL, 8'hff);
        rd(ADDR_CONTROL, 8'hed, 8'hed);
        ien = 1'b1;
        ci(1'b1);
        wr(ADDR_CONTROL, 8'h00);
        ci(1'b0);
        // Sixteen-bit mode on the system clock
        lsel = 1'b1;
        wr(ADDR_RELOAD_HIGH, 8'hff);
        rd(ADDR_RELOAD_HIGH, 8'hff, 8'hff);
        wr(ADDR_COUNT_HIGH, 8'hff);
        wr(ADDR_COUNT_LOW, 8'hf0);
        wr(ADDR_CONTROL, 8'h04);
        repeat (40) @(negedge clk);
        rd(ADDR_CONTROL, 8'hc4, 8'hc4);
        ci(1'b1);
        rd(ADDR_COUNT_HIGH, 8'hff, 8'hff);
        // Split mode: high byte halted until run is set, low byte free
        hsel = 1'b1;
        wr(ADDR_CONTROL, 8'h08);
        wr(ADDR_RELOAD_LOW, 8'hf0);
        wr(ADDR_RELOAD_HIGH, 8'hc0);
        wr(ADDR_COUNT_HIGH, 8'h10);
        wr(ADDR_COUNT_LOW, 8'hfe);
        repeat (40) @(negedge clk);
        rd(ADDR_COUNT_HIGH, 8'h10, 8'h10);
        rd(ADDR_CONTROL, 8'h48, 8'h48);
        ci(1'b0);
        rd(ADDR_COUNT_LOW, 8'hf0, 8'hff);
        wr(ADDR_CONTROL, 8'h2c);
        repeat (40) @(negedge clk);
        rd(ADDR_CONTROL, 8'h6c, 8'h6c);
        ci(1'b1);
        rd(ADDR_COUNT_HIGH, 8'h30, 8'h40);
        wr(ADDR_COUNT_HIGH, 8'hfc);
        repeat (10) @(negedge clk);
        rd(ADDR_CONTROL, 8'hec, 8'hec);
        rd(ADDR_COUNT_HIGH, 8'hc0, 8'hcf);
        // Divided clocks in sixteen-bit mode
        lsel = 1'b0;
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_CONTROL, 8'h04);
        repeat (120) @(negedge clk);
        rd(ADDR_COUNT_LOW, 8'h09, 8'h0b);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_CONTROL, 8'h05);
        repeat (520) @(negedge clk);
        rd(ADDR_COUNT_LOW, 8'h09, 8'h0b);
        // Qualifier set: split bit alone must not free-run the low byte
        qual = 1'b1;
        wr(ADDR_CONTROL, 8'h08);
        wr(ADDR_COUNT_LOW, 8'h00);
        repeat (40) @(negedge clk);
        rd(ADDR_COUNT_LOW, 8'h00, 8'h00);
        close_out();
    end
endmodule // srtmr_timer_bench
`default_nettype wire
